// file: shared/dram_pkg.sv
/*
  Shared constants for the display RAM write path: RAM geometry, drive modes,
  pointer steps and the command kinds that pass between host and device ends.
  Assumes a single 100 MHz clock domain shared by both ends.
*/
package dram_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] RAM_DEPTH = 6'h3c;
  localparam logic [5:0] LAST_ADDR = 6'h3b;
  localparam logic [5:0] ADDR_ZERO = 6'h00;
  localparam int unsigned ROWS = 4;
  localparam int unsigned SUB_W = 3;
  localparam logic [2:0] SUB_RESET = 3'h0;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W = 10;

  typedef enum logic [1:0] {
    MODE_STATIC = 2'b00,
    MODE_MUX2 = 2'b01,
    MODE_MUX3 = 2'b10,
    MODE_MUX4 = 2'b11
  } dram_mode_e;

  // Kind of each word that travels from host to device.
  typedef enum logic [1:0] {
    KIND_DATA = 2'b00,
    KIND_PTR = 2'b01,
    KIND_SEL = 2'b10,
    KIND_MODE = 2'b11
  } dram_kind_e;

  localparam logic [5:0] STEP_STATIC = 6'h08;
  localparam logic [5:0] STEP_MUX2 = 6'h04;
  localparam logic [5:0] STEP_MUX3 = 6'h03;
  localparam logic [5:0] STEP_MUX4 = 6'h02;
  localparam logic [1:0] MODE_RESET = 2'b00;
endpackage : dram_pkg

// file: shared/dram_link_if.sv
/*
  Link between the host end and the display RAM end: a valid/ready stream of
  typed words (kind plus byte) and an abort strobe for a truncated transfer.
  Assumes both ends share i_clk.
*/
`timescale 1ns/1ps
interface dram_link_if;
  logic valid;
  logic ready;
  logic [1:0] kind;
  logic [7:0] data;
  logic abort;

  modport host (output valid, output kind, output data, output abort, input ready);
  modport dev (input valid, input kind, input data, input abort, output ready);
endinterface : dram_link_if

// file: logic/dram_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and honest full and empty.
  Assumes a single synchronous clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module dram_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Async reset, active low.
  input wire logic i_in_valid, // Word offered.
  output logic o_in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] i_in_data, // Word in.
  output logic o_out_valid, // Word available.
  input wire logic i_out_ready, // Consumer takes word.
  output logic [WIDTH-1:0] o_out_data // Head word.
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  // The count is one bit wider than the pointers, so a full queue never reads as empty.
  wire full = (cnt_reg == (PW+1)'(DEPTH));
  assign o_in_ready = !full;
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_mem
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) mem_reg[g] <= '0;
        else if (push && wr_reg == PW'(g)) mem_reg[g] <= i_in_data;
      end
    end
  endgenerate
endmodule : dram_fifo

// file: logic/dram_dev.sv
/*
  Display RAM write end: takes data, pointer-load, chip-select and mode words
  from the link, spreads display bytes over the 60 x 4 RAM by drive mode and
  advances the pointer and subaddress counter.
  Assumes words arrive already decoded by a bus engine, in order, on i_clk.
//
// Contract
// - Static: byte bits into row 0, eight addresses.
// - 1:2: bit pairs, rows 0-1, four addresses.
// - 1:3: bit triples, rows 0-2, three addresses.
// - 1:3: third address row 2 untouched.
// - 1:4: nibbles into rows 0-3, two addresses.
// - Host loads pointer; bytes stored from pointer.
// - Pointer steps 8, 4, 3, 2 by mode.
// - Host reloads pointer after truncated transfer.
// - Store only when counter equals strapped subaddress.
// - Chip-select word loads subaddress counter.
// - Mismatch suppresses write, pointer still advances.
// - Pointer overflow increments subaddress counter.
// - Host selects each cascaded device then loads pointer.
// - Strapped subaddress kept steady during access.
*/
`timescale 1ns/1ps
module dram_dev (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Async reset, active low.
  dram_link_if.dev link, // Stream from host end.
  input wire logic i_hw_subaddr_bit0, // Strapped subaddress bit 0.
  input wire logic i_hw_subaddr_bit1, // Strapped subaddress bit 1.
  input wire logic i_hw_subaddr_bit2, // Strapped subaddress bit 2.
  input wire logic [5:0] i_rd_addr, // Display-side read address.
  output logic [3:0] o_rd_data, // RAM column at i_rd_addr.
  output logic [5:0] o_ptr, // Data pointer.
  output logic [2:0] o_subaddr, // Subaddress counter.
  output logic [1:0] o_mode, // Drive mode.
  output logic o_ptr_valid // Pointer loaded and not aborted.
);
  logic [3:0] ram_reg [dram_pkg::RAM_DEPTH];
  logic [5:0] ptr_reg;
  logic [2:0] sub_reg;
  logic [1:0] mode_reg;
  logic pv_reg;

  wire f_valid;
  wire f_ready;
  wire [9:0] f_data;
  wire [1:0] w_kind = f_data[9:8];
  wire [7:0] w_byte = f_data[7:0];
  assign f_ready = 1'b1;

  dram_fifo #(.WIDTH(dram_pkg::FIFO_W), .DEPTH(dram_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(link.valid),
    .o_in_ready(link.ready),
    .i_in_data({link.kind, link.data}),
    .o_out_valid(f_valid),
    .i_out_ready(f_ready),
    .o_out_data(f_data)
  );

  wire take = f_valid && f_ready;
  wire is_data = take && (w_kind == dram_pkg::KIND_DATA);
  wire [2:0] hw_sub = {i_hw_subaddr_bit2, i_hw_subaddr_bit1, i_hw_subaddr_bit0};
  wire match = (sub_reg == hw_sub);
  wire do_store = is_data && match;

  // Step and resulting pointer; overflow wraps and bumps the subaddress.
  wire [5:0] step = (mode_reg == dram_pkg::MODE_STATIC) ? dram_pkg::STEP_STATIC :
                    (mode_reg == dram_pkg::MODE_MUX2) ? dram_pkg::STEP_MUX2 :
                    (mode_reg == dram_pkg::MODE_MUX3) ? dram_pkg::STEP_MUX3 :
                    dram_pkg::STEP_MUX4;
  wire [6:0] ptr_sum = {1'b0, ptr_reg} + {1'b0, step};
  wire ovf = ptr_sum >= {1'b0, dram_pkg::RAM_DEPTH};
  wire [5:0] ptr_adv = ovf ? dram_pkg::ADDR_ZERO : ptr_sum[5:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg <= dram_pkg::ADDR_ZERO;
      sub_reg <= dram_pkg::SUB_RESET;
      mode_reg <= dram_pkg::MODE_RESET;
      pv_reg <= 1'b0;
    end else begin
      if (take && w_kind == dram_pkg::KIND_PTR) begin
        // The whole byte is compared, so a value above the RAM never aliases into it.
        ptr_reg <= (w_byte > {2'h0, dram_pkg::LAST_ADDR}) ? dram_pkg::ADDR_ZERO : w_byte[5:0];
        pv_reg <= 1'b1;
      end else if (is_data) begin
        ptr_reg <= ptr_adv;
      end
      if (link.abort) pv_reg <= 1'b0;
      if (take && w_kind == dram_pkg::KIND_SEL) sub_reg <= w_byte[2:0];
      else if (is_data && ovf) sub_reg <= sub_reg + 3'h1;
      if (take && w_kind == dram_pkg::KIND_MODE) mode_reg <= w_byte[1:0];
    end
  end

  // Per address: offset from pointer selects which slice of the byte lands here.
  genvar a, r;
  generate
    for (a = 0; a < dram_pkg::RAM_DEPTH; a++) begin : g_col
      wire [5:0] off = 6'(a) - ptr_reg;
      logic [3:0] nv;
      logic [3:0] we;
      always_comb begin
        nv = ram_reg[a];
        we = 4'h0;
        case (mode_reg)
          dram_pkg::MODE_STATIC: begin
            if (6'(a) >= ptr_reg && off < 6'h08) begin
              we = 4'h1;
              nv[0] = w_byte[3'h7 - off[2:0]];
            end
          end
          dram_pkg::MODE_MUX2: begin
            if (6'(a) >= ptr_reg && off < 6'h04) begin
              we = 4'h3;
              nv[0] = w_byte[3'h7 - {off[1:0], 1'b0}];
              nv[1] = w_byte[3'h6 - {off[1:0], 1'b0}];
            end
          end
          dram_pkg::MODE_MUX3: begin
            if (6'(a) >= ptr_reg && off < 6'h03) begin
              we = (off == 6'h02) ? 4'h3 : 4'h7;
              nv[0] = w_byte[3'(4'h7 - 4'(off) * 4'h3)];
              nv[1] = w_byte[3'(4'h6 - 4'(off) * 4'h3)];
              if (off != 6'h02) nv[2] = w_byte[3'(4'h5 - 4'(off) * 4'h3)];
            end
          end
          default: begin
            if (6'(a) >= ptr_reg && off < 6'h02) begin
              we = 4'hf;
              nv = off[0] ? w_byte[3:0] : w_byte[7:4];
            end
          end
        endcase
      end
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) ram_reg[a] <= 4'h0;
        else if (do_store && we != 4'h0) ram_reg[a] <= nv;
      end
    end
  endgenerate

  assign o_rd_data = (i_rd_addr <= dram_pkg::LAST_ADDR) ? ram_reg[i_rd_addr] : 4'h0;
  assign o_ptr = ptr_reg;
  assign o_subaddr = sub_reg;
  assign o_mode = mode_reg;
  assign o_ptr_valid = pv_reg;
endmodule : dram_dev

// file: logic/dram_host.sv
/*
  Host end: turns user requests into link words. A user request is one word
  of a given kind; the host holds it until the link accepts it.
  Assumes the user keeps i_req high with stable fields until o_ack.
*/
`timescale 1ns/1ps
module dram_host (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Async reset, active low.
  dram_link_if.host link, // Stream to device end.
  input wire logic i_req, // Request a word.
  input wire logic [1:0] i_kind, // Word kind.
  input wire logic [7:0] i_data, // Word payload.
  input wire logic i_abort, // Truncated transfer strobe.
  output logic o_ack, // Word accepted, one-cycle pulse.
  output logic o_need_ptr // Pointer must be reloaded before data.
);
  logic need_reg;
  wire accept = i_req && link.ready;
  // Data is held back until a pointer load follows any abort, chip-select or reset.
  wire blocked = (i_kind == dram_pkg::KIND_DATA) && need_reg;
  assign link.valid = i_req && !blocked;
  assign link.kind = i_kind;
  assign link.data = i_data;
  assign link.abort = i_abort;
  assign o_ack = accept && !blocked;
  assign o_need_ptr = need_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) need_reg <= 1'b1;
    else if (i_abort) need_reg <= 1'b1;
    else if (o_ack && i_kind == dram_pkg::KIND_SEL) need_reg <= 1'b1;
    else if (o_ack && i_kind == dram_pkg::KIND_PTR) need_reg <= 1'b0;
  end
endmodule : dram_host

// file: dv/dram_link_props.sv
/*
  Checker for the link words and the pointer state of the display RAM end.
  Assumes one clock and that a word executes one edge after it is taken.
*/
`timescale 1ns/1ps
module dram_link_props (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic valid, // Word offered.
  input wire logic ready, // Device has room.
  input wire logic [1:0] kind, // Word kind.
  input wire logic [7:0] data, // Word payload.
  input wire logic abort, // Truncation strobe.
  input wire logic [5:0] o_ptr, // Data pointer.
  input wire logic [2:0] o_subaddr, // Subaddress counter.
  input wire logic [1:0] o_mode, // Drive mode.
  input wire logic o_ptr_valid // Pointer usable.
);
  logic ex_reg;
  logic [1:0] kind_reg;
  logic [7:0] data_reg;
  logic need_reg;
  wire logic take = valid && ready;
  wire logic need_next = (abort || (take && kind == dram_pkg::KIND_SEL)) ? 1'b1 :
    (take && kind == dram_pkg::KIND_PTR) ? 1'b0 : need_reg;
  wire logic [6:0] step = (o_mode == 2'b00) ? 7'h08 : (o_mode == 2'b01) ? 7'h04 :
    (o_mode == 2'b10) ? 7'h03 : 7'h02;
  wire logic [6:0] nxt = {1'b0, o_ptr} + step;
  wire logic ex_data = ex_reg && (kind_reg == dram_pkg::KIND_DATA);
  wire logic [5:0] ld_val = (data_reg < 8'h3c) ? data_reg[5:0] : 6'h00;
  wire logic [2:0] sel_val = data_reg[2:0];
  wire logic [1:0] md_val = data_reg[1:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ex_reg <= 1'b0;
      need_reg <= 1'b1;
    end else begin
      ex_reg <= take;
      need_reg <= need_next;
    end
  end
  always_ff @(posedge i_clk) begin
    kind_reg <= kind;
    data_reg <= data;
  end
  AST_PTR_LOAD: assert property (ex_reg && kind_reg == dram_pkg::KIND_PTR
    |=> o_ptr == $past(ld_val) && o_ptr_valid) else $error("pointer load wrong");
  AST_SEL_LOAD: assert property (ex_reg && kind_reg == dram_pkg::KIND_SEL
    |=> o_subaddr == $past(sel_val)) else $error("subaddress load wrong");
  AST_MODE_LOAD: assert property (ex_reg && kind_reg == dram_pkg::KIND_MODE
    |=> o_mode == $past(md_val)) else $error("mode load wrong");
  AST_STEP: assert property (ex_data && nxt < 7'h3c
    |=> {1'b0, o_ptr} == $past(nxt) && $stable(o_subaddr)) else $error("pointer step wrong");
  AST_WRAP: assert property (ex_data && nxt >= 7'h3c
    |=> o_ptr == 6'h00 && o_subaddr == $past(o_subaddr) + 3'h1) else $error("wrap wrong");
  AST_HOLD: assert property (!ex_reg
    |=> $stable(o_ptr) && $stable(o_subaddr) && $stable(o_mode)) else $error("state moved");
  AST_ABORT: assert property (abort |-> ##[1:3] !o_ptr_valid)
    else $error("abort not seen");
  AST_GATE: assert property (valid && kind == dram_pkg::KIND_DATA |-> !need_reg)
    else $error("data before pointer load");
endmodule : dram_link_props

// file: dv/display_ram_write_addressing_tb.sv
/*
  Testbench joining host and device ends; a model predicts pointer, counter,
  mode and RAM. Assumes the strap stays at a fixed subaddress throughout.
*/
`timescale 1ns/1ps
module display_ram_write_addressing_tb;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk, rst_n, req, abrt, ack, need_ptr, pv;
  logic [1:0] kind, mode;
  logic [7:0] dat;
  logic [5:0] rd_addr, ptr, m_ptr;
  logic [3:0] rd_data;
  logic [2:0] sub, m_sub;
  logic [1:0] m_mode;
  logic [3:0] m_ram [60];
  logic [7:0] pt [4] = '{8'h12, 8'h11, 8'h10, 8'h0e};
  logic [7:0] by [4] = '{8'hff, 8'h5a, 8'hc3, 8'h96};
  int fail_count, checks_done;
  dram_link_if link_bus ();
  dram_host dram_host_inst (.i_clk(clk), .i_rst_n(rst_n), .link(link_bus), .i_req(req),
    .i_kind(kind), .i_data(dat), .i_abort(abrt), .o_ack(ack), .o_need_ptr(need_ptr));
  dram_dev dram_dev_inst (.i_clk(clk), .i_rst_n(rst_n), .link(link_bus),
    .i_hw_subaddr_bit0(STRAP[0]), .i_hw_subaddr_bit1(STRAP[1]), .i_hw_subaddr_bit2(STRAP[2]),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_ptr(ptr), .o_subaddr(sub), .o_mode(mode),
    .o_ptr_valid(pv));
  dram_link_props dram_link_props_inst (.i_clk(clk), .i_rst_n(rst_n), .valid(link_bus.valid),
    .ready(link_bus.ready), .kind(link_bus.kind), .data(link_bus.data), .abort(link_bus.abort),
    .o_ptr(ptr), .o_subaddr(sub), .o_mode(mode), .o_ptr_valid(pv));
  always #5 clk = ~clk;
  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Called at a falling edge; returns at the falling edge after the taking edge.
  task send(input logic [1:0] k, input logic [7:0] d);
    int n, c, w, i;
    w = (m_mode == 2'h0) ? 1 : m_mode + 1;
    if (k == dram_pkg::KIND_PTR) m_ptr = (d < 8'h3c) ? d[5:0] : 6'h00;
    if (k == dram_pkg::KIND_SEL) m_sub = d[2:0];
    if (k == dram_pkg::KIND_MODE) m_mode = d[1:0];
    if (k == dram_pkg::KIND_DATA) begin
      for (i = 0; i < 8; i++) begin
        c = m_ptr + i / w;
        if (m_sub == STRAP && c < 60) m_ram[c][(m_mode == 2'h3) ? 3 - i % 4 : i % w] = d[7 - i];
      end
      c = m_ptr + (8 + w - 1) / w;
      m_sub = (c >= 60) ? m_sub + 3'h1 : m_sub;
      m_ptr = (c >= 60) ? 6'h00 : c[5:0];
    end
    kind = k;
    dat = d;
    req = 1'b1;
    n = 0;
    #1;
    while (ack !== 1'b1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n == 20) begin
      fail_count++;
      $display("Error at %0t: no acknowledge", $time);
      complete_run();
    end
    @(negedge clk);
  endtask : send
  task check(input string name);
    req = 1'b0;
    repeat (2) @(negedge clk);
    cmp(ptr, m_ptr);
    cmp(sub, m_sub);
    cmp(mode, m_mode);
    for (int c = 0; c < 64; c++) begin
      rd_addr = c[5:0];
      @(negedge clk);
      cmp(rd_data, (c < 60) ? m_ram[c] : 4'h0);
    end
    $display("test %s done", name);
  endtask : check
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {req, abrt, kind, dat, rd_addr} = '0;
    {m_ptr, m_sub, m_mode} = '0;
    foreach (m_ram[c]) m_ram[c] = 4'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    check("reset");
    for (int j = 0; j < 4; j++) begin
      send(dram_pkg::KIND_MODE, 8'(3 - j));
      send(dram_pkg::KIND_SEL, {5'h00, STRAP});
      send(dram_pkg::KIND_PTR, pt[j]);
      send(dram_pkg::KIND_DATA, by[j]);
      check("modes");
    end
    send(dram_pkg::KIND_SEL, 8'h03);
    send(dram_pkg::KIND_PTR, 8'h00);
    send(dram_pkg::KIND_DATA, 8'hff);
    check("mismatch");
    send(dram_pkg::KIND_SEL, {5'h00, STRAP});
    send(dram_pkg::KIND_PTR, 8'h3a);
    send(dram_pkg::KIND_DATA, 8'h81);
    send(dram_pkg::KIND_DATA, 8'h7e);
    check("wrap");
    abrt = 1'b1;
    @(negedge clk);
    abrt = 1'b0;
    {req, kind, dat} = {1'b1, dram_pkg::KIND_DATA, 8'h00};
    repeat (4) @(negedge clk);
    cmp(ack, 1'b0);
    cmp(need_ptr, 1'b1);
    cmp(pv, 1'b0);
    req = 1'b0;
    @(negedge clk);
    send(dram_pkg::KIND_PTR, 8'h3f);
    send(dram_pkg::KIND_DATA, 8'h3c);
    check("abort");
    cmp(pv, 1'b1);
    complete_run();
  end
endmodule : display_ram_write_addressing_tb
